// [hdl/fbt_pkg.sv]
package fbt_pkg;

  // Trigger sources selectable for each trigger.
  typedef enum logic [1:0] {
    FBT_SRC_LINE1    = 2'h0,
    FBT_SRC_LINE2    = 2'h1,
    FBT_SRC_SOFTWARE = 2'h2,
    FBT_SRC_NONE     = 2'h3
  } fbt_src_t;

  // Edge selection for a line source.
  typedef enum logic [1:0] {
    FBT_ACT_RISE  = 2'h0,
    FBT_ACT_FALL  = 2'h1,
    FBT_ACT_ANY   = 2'h2,
    FBT_ACT_NONE  = 2'h3
  } fbt_act_t;

  // Acquisition status seen by software.
  typedef enum logic [1:0] {
    FBT_ST_IDLE       = 2'h0,
    FBT_ST_WAIT_BURST = 2'h1,
    FBT_ST_WAIT_FRAME = 2'h2
  } fbt_status_t;

  // Field widths.
  localparam int unsigned FBT_CNT_W    = 16;
  localparam int unsigned FBT_PERIOD_W = 24;

  // Reset values.
  localparam logic [FBT_CNT_W-1:0]    FBT_CNT_RST    = 16'h0000;
  localparam logic [FBT_PERIOD_W-1:0] FBT_PERIOD_RST = 24'h000000;

  // Clock and the shortest frame period at the maximum allowed rate.
  localparam int unsigned FBT_CLK_HZ         = 25000000;
  localparam int unsigned FBT_MIN_PERIOD_NS  = 1000;
  localparam int unsigned FBT_MIN_PERIOD_CYC =
    (FBT_MIN_PERIOD_NS * (FBT_CLK_HZ / 1000000) + 999) / 1000;

  // Configuration from software.
  typedef struct packed {
    logic                    acq_start;
    logic                    continuous;
    logic                    burst_trig_on;
    fbt_src_t                burst_src;
    fbt_act_t                burst_act;
    logic                    frame_trig_on;
    fbt_src_t                frame_src;
    fbt_act_t                frame_act;
    logic                    rate_limit_en;
    logic [FBT_PERIOD_W-1:0] rate_period;
    logic [FBT_PERIOD_W-1:0] settings_period;
    logic [FBT_CNT_W-1:0]    burst_count;
  } fbt_cfg_t;

  // Status back to software.
  typedef struct packed {
    fbt_status_t          status;
    logic                 frame_start;
    logic                 burst_start;
    logic                 frame_dropped;
    logic [FBT_CNT_W-1:0] frames_in_burst;
  } fbt_stat_t;

endpackage

// [hdl/fbt_edge.sv]
`timescale 1ns/1ps
`default_nettype none

module fbt_edge (
  // Clock and reset.
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  // Line levels, software pulse and selection.
  input  wire logic [1:0]      lines_i,
  input  wire logic            sw_i,
  input  wire fbt_pkg::fbt_src_t src_i,
  input  wire fbt_pkg::fbt_act_t act_i,
  // One-cycle trigger pulse.
  output logic                 trig_o
);
  import fbt_pkg::*;

  typedef struct packed {
    logic [1:0] prev;
  } fbt_edge_state_t;

  fbt_edge_state_t s_q;
  fbt_edge_state_t s_d;
  logic            lvl;
  logic            old;

  // Pick the line and its previous level; the trigger is combinational so it adds no latency.
  always_comb begin
    s_d.prev = lines_i;
    lvl      = (src_i == FBT_SRC_LINE2) ? lines_i[1] : lines_i[0];
    old      = (src_i == FBT_SRC_LINE2) ? s_q.prev[1] : s_q.prev[0];
    trig_o   = 1'b0;
    unique case (src_i)
      FBT_SRC_SOFTWARE: trig_o = sw_i;
      FBT_SRC_NONE:     trig_o = 1'b0;
      default: begin
        unique case (act_i)
          FBT_ACT_RISE: trig_o = lvl & ~old;
          FBT_ACT_FALL: trig_o = ~lvl & old;
          FBT_ACT_ANY:  trig_o = lvl ^ old;
          FBT_ACT_NONE: trig_o = 1'b0;
        endcase
      end
    endcase
  end

  // Previous line levels; reset low, so a line high at release reads as a rising edge.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '{prev: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// [hdl/fbt_sequencer.sv]
// Behaviour
// - With both triggers off and continuous acquisition, all triggers are internal and frames run continuously.
// - Internal frame starts follow the programmed rate limit unless settings force a slower rate.
// - With the rate limit disabled, internal frame starts come at the maximum rate the settings allow.
// - With burst trigger mode off, burst starts are generated internally with no outside signal.
// - With frame trigger mode on, exposure starts only on a frame trigger from the source, one per frame.
// - A line source with rising-edge activation triggers on each low-to-high transition.
// - With burst triggering on, a burst trigger edge moves waiting-for-burst to waiting-for-frame.
// - After the programmed number of frames the sequencer returns to waiting-for-burst in continuous mode, or to idle in single-shot.
// - After a burst, no frame is taken until a new burst trigger edge arrives.
// - While waiting for a burst start, frame triggers including internal ones are ignored.
// - With burst on and frame off, each internal frame trigger while waiting-for-frame takes and counts a frame.
`timescale 1ns/1ps
`default_nettype none

module fbt_sequencer (
  // Clock and reset.
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  // Input lines and software commands.
  input  wire logic [1:0]         lines_i,
  input  wire logic               sw_burst_i,
  input  wire logic               sw_frame_i,
  // Configuration.
  input  wire fbt_pkg::fbt_cfg_t  cfg_i,
  // Status and trigger outputs.
  output fbt_pkg::fbt_stat_t      stat_o
);
  import fbt_pkg::*;

  typedef enum logic [1:0] {
    FBT_S_IDLE,
    FBT_S_WAIT_BURST,
    FBT_S_WAIT_FRAME
  } fbt_fsm_t;

  typedef struct packed {
    fbt_fsm_t                fsm;
    logic [FBT_PERIOD_W-1:0] timer;
    logic [FBT_CNT_W-1:0]    frames;
    fbt_stat_t               stat;
  } fbt_state_t;

  fbt_state_t s_q;
  fbt_state_t s_d;
  logic       ext_burst;
  logic       ext_frame;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detectors for the two triggers.

  fbt_edge u_burst_edge (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .lines_i (lines_i),
    .sw_i    (sw_burst_i),
    .src_i   (cfg_i.burst_src),
    .act_i   (cfg_i.burst_act),
    .trig_o  (ext_burst)
  );

  fbt_edge u_frame_edge (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .lines_i (lines_i),
    .sw_i    (sw_frame_i),
    .src_i   (cfg_i.frame_src),
    .act_i   (cfg_i.frame_act),
    .trig_o  (ext_frame)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame period: the slowest of rate limit (when rate_limit_en is set), settings and sensor floor.

  // Larger of two periods, used twice below.
  function automatic logic [FBT_PERIOD_W-1:0] fbt_max(input logic [FBT_PERIOD_W-1:0] a,
                                                      input logic [FBT_PERIOD_W-1:0] b);
    fbt_max = (a > b) ? a : b;
  endfunction

  logic [FBT_PERIOD_W-1:0] floor_period;
  logic [FBT_PERIOD_W-1:0] period;
  logic                    int_tick;
  logic                    burst_go;
  logic                    frame_go;
  logic                    last_frame;

  // A slower settings period always wins over the programmed limit, so the limit is only a ceiling.
  always_comb begin
    floor_period = fbt_max(cfg_i.settings_period, FBT_PERIOD_W'(FBT_MIN_PERIOD_CYC));
    period       = cfg_i.rate_limit_en ? fbt_max(cfg_i.rate_period, floor_period)
                                       : floor_period;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // The internal timer free-runs while acquiring so internal triggers keep their pacing.
  always_comb begin
    s_d                   = s_q;
    s_d.stat.frame_start  = 1'b0;
    s_d.stat.burst_start  = 1'b0;
    s_d.stat.frame_dropped = 1'b0;
    int_tick   = (s_q.timer == '0);
    burst_go   = cfg_i.burst_trig_on ? ext_burst : 1'b1;
    frame_go   = cfg_i.frame_trig_on ? ext_frame : int_tick;
    last_frame = (cfg_i.burst_count != '0) && (s_q.frames + 16'h0001 >= cfg_i.burst_count);

    if (s_q.fsm == FBT_S_IDLE || int_tick) begin
      s_d.timer = period - 24'h000001;
    end else begin
      s_d.timer = s_q.timer - 24'h000001;
    end

    unique case (s_q.fsm)
      FBT_S_IDLE: begin
        if (cfg_i.acq_start) begin
          s_d.fsm = FBT_S_WAIT_BURST;
        end
      end
      FBT_S_WAIT_BURST: begin
        // Frame triggers arriving here are dropped and reported.
        s_d.stat.frame_dropped = frame_go;
        if (!cfg_i.acq_start) begin
          s_d.fsm = FBT_S_IDLE;
        end else if (burst_go) begin
          s_d.fsm              = FBT_S_WAIT_FRAME;
          s_d.frames           = FBT_CNT_RST;
          s_d.stat.burst_start = 1'b1;
        end
      end
      FBT_S_WAIT_FRAME: begin
        if (!cfg_i.acq_start) begin
          s_d.fsm = FBT_S_IDLE;
        end else if (frame_go) begin
          s_d.stat.frame_start = 1'b1;
          s_d.frames           = s_q.frames + 16'h0001;
          if (last_frame) begin
            s_d.fsm = FBT_S_WAIT_BURST;
          end
        end
      end
      default: s_d.fsm = FBT_S_IDLE;
    endcase

    // Continuous mode keeps rearming; single-shot drops to idle after one burst and rearms from there while acq_start is held.
    if (s_q.fsm == FBT_S_WAIT_FRAME && frame_go && last_frame && !cfg_i.continuous) begin
      s_d.fsm = FBT_S_IDLE;
    end

    unique case (s_d.fsm)
      FBT_S_WAIT_BURST: s_d.stat.status = FBT_ST_WAIT_BURST;
      FBT_S_WAIT_FRAME: s_d.stat.status = FBT_ST_WAIT_FRAME;
      default:          s_d.stat.status = FBT_ST_IDLE;
    endcase
    s_d.stat.frames_in_burst = s_d.frames;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; all outputs are copies of it.

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q <= '{fsm: FBT_S_IDLE, timer: FBT_PERIOD_RST, frames: FBT_CNT_RST,
               stat: '{status: FBT_ST_IDLE, frame_start: 1'b0, burst_start: 1'b0,
                       frame_dropped: 1'b0, frames_in_burst: FBT_CNT_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  assign stat_o = s_q.stat;

endmodule
`default_nettype wire

// [tb/fbt_line_src.sv]
`timescale 1ns/1ps
`default_nettype none

module fbt_line_src (
  // Clock and request.
  input  wire logic clock_i,
  input  wire logic fire_i,
  // Driven line, idles low.
  output logic      line_o
);
  logic [1:0] hold_q = 2'h0;

  // Each request makes one pulse two cycles wide, so every frame or burst gets its own edge.
  always_ff @(posedge clock_i) begin
    hold_q <= fire_i ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
  end
  assign line_o = hold_q != 2'h0;
endmodule
`default_nettype wire

// [tb/fbt_sequencer_properties.sv]
`timescale 1ns/1ps
`default_nettype none

module fbt_sequencer_properties (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic [1:0]        lines_i,
  input  wire logic              sw_burst_i,
  input  wire logic              sw_frame_i,
  input  wire fbt_pkg::fbt_cfg_t cfg_i,
  input  wire fbt_pkg::fbt_stat_t stat_o
);
  import fbt_pkg::*;
  logic [FBT_PERIOD_W-1:0] gap_q;
  logic [FBT_PERIOD_W-1:0] per_w;
  logic                    seen_q;
  fbt_stat_t               s;

  assign s = stat_o;
  // Expected free-run period; the slowest limit wins.
  always_comb begin
    per_w = FBT_PERIOD_W'(FBT_MIN_PERIOD_CYC);
    if (cfg_i.settings_period > per_w) per_w = cfg_i.settings_period;
    if (cfg_i.rate_limit_en && cfg_i.rate_period > per_w) per_w = cfg_i.rate_period;
  end
  // Gap is only judged after one frame in unbroken free run, since the first one starts mid-period.
  always_ff @(posedge clock_i) begin
    gap_q  <= s.frame_start ? 24'h000001 : gap_q + 24'h000001;
    seen_q <= !rst_i && cfg_i.acq_start && cfg_i.continuous && !cfg_i.burst_trig_on
              && !cfg_i.frame_trig_on && cfg_i.burst_count == 16'h0000 && (seen_q || s.frame_start);
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_frame_in_wait: assert property (s.frame_start |-> $past(s.status) == FBT_ST_WAIT_FRAME)
    else $error("Frame start outside wait frame.");
  a_burst_from_wait: assert property (s.burst_start |-> $past(s.status) == FBT_ST_WAIT_BURST)
    else $error("Burst start outside wait burst.");
  a_burst_clears: assert property (s.burst_start |-> s.status == FBT_ST_WAIT_FRAME && s.frames_in_burst == 16'h0000)
    else $error("Burst entry did not clear count.");
  a_frame_counts: assert property (s.frame_start |-> s.frames_in_burst == $past(s.frames_in_burst) + 16'h0001)
    else $error("Frame not counted.");
  a_burst_ends: assert property (s.frame_start && cfg_i.continuous && cfg_i.burst_count != 16'h0000
    && s.frames_in_burst == cfg_i.burst_count |-> s.status == FBT_ST_WAIT_BURST) else $error("Burst did not end.");
  a_line_rise: assert property (s.frame_start && cfg_i.frame_trig_on && cfg_i.frame_src == FBT_SRC_LINE1
    && cfg_i.frame_act == FBT_ACT_RISE |-> $past(lines_i[0]) && !$past(lines_i[0], 2)) else $error("Frame without edge.");
  a_dropped_wait: assert property (s.frame_dropped |-> $past(s.status) == FBT_ST_WAIT_BURST)
    else $error("Drop outside wait burst.");
  a_auto_burst: assert property (!cfg_i.burst_trig_on && cfg_i.acq_start && s.status == FBT_ST_WAIT_BURST
    ##1 cfg_i.acq_start |-> s.burst_start) else $error("Internal burst start missing.");
  a_free_period: assert property (seen_q && s.frame_start |-> gap_q == per_w)
    else $error("Free-run period wrong.");

  c_burst: cover property (s.burst_start);
  c_last_frame: cover property (s.frame_start && s.status == FBT_ST_WAIT_BURST);
  c_dropped: cover property (s.frame_dropped);
endmodule

bind fbt_sequencer fbt_sequencer_properties fbt_sequencer_properties_i (.clock_i(clock_i), .rst_i(rst_i),
  .lines_i(lines_i), .sw_burst_i(sw_burst_i), .sw_frame_i(sw_frame_i), .cfg_i(cfg_i), .stat_o(stat_o));
`default_nettype wire

// [tb/fbt_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module fbt_sequencer_tb_top;
  import fbt_pkg::*;
  logic      clock_i;
  logic      rst_i;
  logic      fire;
  logic      line_w;
  fbt_cfg_t  cfg;
  fbt_stat_t stat;
  int        bad_count = 0;
  int        checks = 0;
  int        n;
  int        nf;
  int        nd;

  fbt_line_src fbt_line_src_i (.clock_i(clock_i), .fire_i(fire), .line_o(line_w));
  fbt_sequencer fbt_sequencer_i (.clock_i(clock_i), .rst_i(rst_i), .lines_i({1'b0, line_w}),
    .sw_burst_i(1'b0), .sw_frame_i(1'b0), .cfg_i(cfg), .stat_o(stat));

  // 25 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clock_i);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Waits for a burst or frame pulse; the bound keeps a dead design from hanging here.
  task automatic wait_ev(input logic sel, output int cyc);
    cyc = 0;
    do begin
      step(1);
      cyc++;
    end while (!(sel ? stat.burst_start : stat.frame_start) && cyc < 300);
    // A pulse that never came is a mismatch, not a silent fall-through.
    if ((sel ? stat.burst_start : stat.frame_start) !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask
  task automatic tally(input int k);
    nf = 0;
    nd = 0;
    repeat (k) begin
      step(1);
      nf += int'(stat.frame_start === 1'b1);
      nd += int'(stat.frame_dropped === 1'b1);
    end
  endtask
  // Settings change only while stopped, so no half-applied mode is seen.
  task automatic start(input logic b_on, f_on, en, input logic [23:0] sett, input logic [15:0] cnt);
    cfg.acq_start = 1'b0;
    step(3);
    {cfg.burst_trig_on, cfg.frame_trig_on, cfg.rate_limit_en} = {b_on, f_on, en};
    cfg.settings_period = sett;
    cfg.burst_count = cnt;
    cfg.acq_start = 1'b1;
  endtask
  task automatic free_gap(input logic en, input logic [23:0] sett, input int exp);
    start(1'b0, 1'b0, en, sett, 16'h0000);
    wait_ev(1'b0, n);
    wait_ev(1'b0, n);
    check(n, exp);
  endtask
  // One request only; the caller waits for the pulse, which stands a single cycle.
  task automatic fire_line;
    fire = 1'b1;
    step(1);
    fire = 1'b0;
  endtask
  task automatic print_verdict;
    $display("Counts: %0d checks, %0d mismatches", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog; all tests need well under 3000 cycles.
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    print_verdict;
  end

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    fire = 1'b0;
    cfg = '0;
    cfg.continuous = 1'b1;
    cfg.rate_period = 24'h000028;
    {cfg.burst_src, cfg.burst_act, cfg.frame_src, cfg.frame_act} = {FBT_SRC_LINE1, FBT_ACT_RISE, FBT_SRC_LINE1, FBT_ACT_RISE};
    step(3);
    rst_i = 1'b0;
    free_gap(1'b1, 24'h00000a, 40);
    free_gap(1'b0, 24'h00000a, FBT_MIN_PERIOD_CYC);
    free_gap(1'b1, 24'h000032, 50);
    $display("Test free run done.");
    start(1'b1, 1'b0, 1'b0, 24'h000000, 16'h0003);
    tally(60);
    check(nf, 0);
    repeat (2) begin
      fire_line;
      wait_ev(1'b1, n);
      check(stat.status, FBT_ST_WAIT_FRAME);
      check(stat.frames_in_burst, 0);
      repeat (3) wait_ev(1'b0, n);
      check(stat.frames_in_burst, 3);
      check(stat.status, FBT_ST_WAIT_BURST);
      tally(100);
      check(nf, 0);
      check(nd != 0, 1);
    end
    $display("Test burst on line done.");
    start(1'b0, 1'b1, 1'b0, 24'h000000, 16'h0000);
    tally(80);
    check(nf, 0);
    for (int k = 1; k <= 2; k++) begin
      fire_line;
      wait_ev(1'b0, n);
      // Partner raises the line one edge late; the pulse is registered on the edge that sees it.
      check(n, 1);
      check(stat.frames_in_burst, k);
      step(5);
    end
    $display("Test frame on line done.");
    cfg.continuous = 1'b0;
    start(1'b0, 1'b0, 1'b0, 24'h000000, 16'h0002);
    repeat (2) wait_ev(1'b0, n);
    check(stat.status, FBT_ST_IDLE);
    check(stat.frames_in_burst, 2);
    $display("Test single shot done.");
    print_verdict;
  end
endmodule
`default_nettype wire
